// [rtl/frac_stage.v]
/*
  one 8-bit stage of the fraction counter with carry in and carry out.
  assumes the caller supplies clock enable, count enable and synchronous clear.
*/
`include "timestamp_defs.vh"
module frac_stage #(
  parameter WIDTH = `STAGE_WIDTH
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             ce,
  input  wire             clear,
  input  wire             carry_in,
  output wire [WIDTH-1:0] count,
  output wire             carry_out
);
  reg  [WIDTH-1:0] count_ff;
  wire [WIDTH-1:0] nxt_count;

  assign nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
  assign count     = count_ff;
  assign carry_out = carry_in & (&count_ff);

  always @(posedge clock) begin
    if (rst) begin
      count_ff <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (clear) begin
        count_ff <= {WIDTH{1'b0}};
      end else if (carry_in) begin
        count_ff <= nxt_count;
      end
    end
  end
endmodule // frac_stage

// [rtl/gps_timestamp_counter.v]
/*
  gps timestamp counter: latches the bcd time of day on the valid strobe and counts
  the fraction of a second from the receiver's 5 mhz clock, flagging overruns.
  assumes the receiver clock, strobe, bcd word and manual clear arrive as asynchronous
  pins, and that the 50 mhz system clock is fast enough to see every receiver edge.
*/
`include "timestamp_defs.vh"
module gps_timestamp_counter #(
  parameter TOD_WIDTH    = `TOD_WIDTH,
  parameter STAGE_WIDTH  = `STAGE_WIDTH,
  parameter STAGE_COUNT  = `STAGE_COUNT,
  parameter [`FRAC_BUS_WIDTH-1:0] ONE_SECOND = `ONE_SECOND_COUNT
) (
  input  wire                               clock,
  input  wire                               rst,
  input  wire                               ce,
  input  wire [TOD_WIDTH-1:0]               bcd_time,
  input  wire                               second_valid_strobe,
  input  wire                               ref_clock_5mhz,
  input  wire                               alarm_clear,
  output reg  [TOD_WIDTH-1:0]               tod_ff,
  output reg  [`FRAC_BUS_WIDTH-1:0]         frac_ff,
  output reg                                alarm_led_ff
);
  localparam CW = STAGE_WIDTH*STAGE_COUNT;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  reg [TOD_WIDTH-1:0] bcd_s1_ff;
  reg [TOD_WIDTH-1:0] bcd_s2_ff;
  reg [2:0]           strobe_ff;
  reg [2:0]           refclk_ff;
  reg [1:0]           aclr_ff;

  always @(posedge clock) begin
    if (rst) begin
      bcd_s1_ff <= `TOD_ZERO;
      bcd_s2_ff <= `TOD_ZERO;
      strobe_ff <= 3'h0;
      refclk_ff <= 3'h0;
      aclr_ff   <= 2'h0;
    end else if (ce) begin
      bcd_s1_ff <= bcd_time;
      bcd_s2_ff <= bcd_s1_ff;
      strobe_ff <= {strobe_ff[1:0], second_valid_strobe};
      refclk_ff <= {refclk_ff[1:0], ref_clock_5mhz};
      aclr_ff   <= {aclr_ff[0], alarm_clear};
    end
  end

  wire strobe_rise = strobe_ff[1] & ~strobe_ff[2];
  wire tick        = refclk_ff[1] & ~refclk_ff[2];
  wire manual_clr  = aclr_ff[1];

  // ------------------------------------------------------------------
  // fraction counter
  // ------------------------------------------------------------------
  wire [STAGE_COUNT:0] carry;
  wire [CW-1:0]        count;
  assign carry[0] = tick;

  genvar g;
  generate
    for (g = 0; g < STAGE_COUNT; g = g + 1) begin : stage
      frac_stage #(
        .WIDTH     (STAGE_WIDTH)
      ) u_stage (
        .clock     (clock),
        .rst       (rst),
        .ce        (ce),
        .clear     (strobe_rise),
        .carry_in  (carry[g]),
        .count     (count[g*STAGE_WIDTH +: STAGE_WIDTH]),
        .carry_out (carry[g+1])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // overrun detection and outputs
  // ------------------------------------------------------------------
  wire overrun = (count[`FRAC_BUS_WIDTH-1:0] >= ONE_SECOND);
  reg  alarm_hold_ff;
  wire nxt_alarm = strobe_rise ? 1'b0 :
                   manual_clr  ? 1'b0 :
                   (alarm_hold_ff | overrun);

  always @(posedge clock) begin
    if (rst) begin
      tod_ff        <= `TOD_ZERO;
      frac_ff       <= `FRAC_ZERO;
      alarm_hold_ff <= 1'b0;
      alarm_led_ff  <= 1'b0;
    end else if (ce) begin
      if (strobe_rise) begin
        tod_ff <= bcd_s2_ff;
      end
      alarm_hold_ff <= nxt_alarm;
      alarm_led_ff  <= nxt_alarm;
      frac_ff[`FRAC_WIDTH-1:0] <= strobe_rise ? {`FRAC_WIDTH{1'b0}}
                                  : count[`FRAC_WIDTH-1:0];
      frac_ff[`ALARM_BIT] <= nxt_alarm;
    end
  end
endmodule // gps_timestamp_counter

// [rtl/timestamp_defs.vh]
/*
  constants for the gps timestamp counter: field widths, bcd layout, counter limits.
  assumes a single 50 mhz system clock; the receiver clock and strobe are sampled pins.
*/
// Summary of operation
// - take 20 bcd hhmmss bits only
// - latch time word on valid strobe
// - three cascaded 8-bit stages count ticks
// - valid strobe, not utc pulse, clears fraction
// - 23-bit fraction, 200 ns per count
// - fraction msb serves as alarm flag
// - overrun sets alarm bit in outputs
// - alarm indicator held until next strobe
// - without strobe, manual clear ends alarm (here only while held; a persisting overrun sets it again on release)
// - capture on strobe before routing out
`ifndef TIMESTAMP_DEFS_VH
`define TIMESTAMP_DEFS_VH
`define TOD_WIDTH        20
`define FRAC_WIDTH       23
`define STAGE_WIDTH      8
`define STAGE_COUNT      3
`define FRAC_BUS_WIDTH   24
`define ALARM_BIT        23
`define ONE_SECOND_COUNT 24'h4c4b40
`define COUNT_PERIOD_NS  200
`define STAGE_ZERO       8'h00
`define STAGE_ONES       8'hff
`define FRAC_ZERO        24'h000000
`define TOD_ZERO         20'h00000
`endif

// [tb/gps_receiver_model.sv]
/* receiver model: free 5 mhz clock, bcd word, valid strobe.
   assumes req pulses at least 12 system cycles apart */
module gps_receiver_model (
  input  wire logic        clock,
  input  wire logic        req,
  input  wire logic [19:0] value,
  output logic             ref_clock_5mhz,
  output logic [19:0]      bcd_time,
  output logic             second_valid_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] n_ff = 4'h0;
  initial bcd_time = 20'h00000;
  initial second_valid_strobe = 1'b0;
  initial begin
    ref_clock_5mhz = 1'b0;
    forever #100 ref_clock_5mhz = ~ref_clock_5mhz;
  end
  // word settles first, strobe only while it is valid
  always @(posedge clock) begin
    if (req) bcd_time <= value;
    n_ff <= req ? 4'h6 : n_ff - {3'h0, n_ff != 4'h0};
    second_valid_strobe <= n_ff != 4'h0 && n_ff < 4'h4;
  end
endmodule // gps_receiver_model

// [tb/gps_timestamp_counter_checker.sv]
/* port checker for gps_timestamp_counter.
   assumes ce held high */
module gps_timestamp_counter_checker #(parameter [23:0] ONE_SECOND = 24'h4c4b40) (
  input wire logic clock, rst, ce, second_valid_strobe, ref_clock_5mhz, alarm_clear, alarm_led_ff,
  input wire logic [19:0] bcd_time, tod_ff,
  input wire logic [23:0] frac_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [4:0] hs_ff, hc_ff;
  wire [22:0] cnt = frac_ff[22:0];
  always_ff @(posedge clock) begin
    hs_ff <= rst ? 5'h00 : {hs_ff[3:0], second_valid_strobe};
    hc_ff <= rst ? 5'h00 : {hc_ff[3:0], alarm_clear};
  end
  a_tod_loads: assert property ($rose(second_valid_strobe) |-> ##[1:5] tod_ff == bcd_time)
    else $error("tod not loaded");
  a_tod_steady: assert property ($changed(tod_ff) |-> |hs_ff)
    else $error("tod moved");
  a_frac_clears: assert property ($rose(second_valid_strobe) |-> ##[1:5] cnt == 23'h0)
    else $error("frac not cleared");
  a_led_clears: assert property ($rose(second_valid_strobe) |-> ##[1:5] !alarm_led_ff)
    else $error("alarm not cleared");
  a_flag_led: assert property (frac_ff[23] == alarm_led_ff)
    else $error("flag and led differ");
  a_overrun_sets: assert property (cnt >= ONE_SECOND[22:0] && !(|hs_ff) && !(|hc_ff) |-> ##[0:2] alarm_led_ff)
    else $error("overrun missed");
  a_alarm_holds: assert property (alarm_led_ff && !(|hs_ff) && !(|hc_ff) |=> alarm_led_ff)
    else $error("alarm dropped");
  a_rise_cause: assert property ($rose(alarm_led_ff) |-> cnt >= ONE_SECOND[22:0])
    else $error("false alarm");
  a_frac_steps: assert property ($changed(cnt) |-> cnt == $past(cnt) + 23'h1 || cnt == 23'h0)
    else $error("frac jumped");
  c_strobe: cover property ($rose(second_valid_strobe));
  c_alarm: cover property ($rose(alarm_led_ff));
  c_clear: cover property (alarm_led_ff && alarm_clear);
endmodule // gps_timestamp_counter_checker
bind gps_timestamp_counter gps_timestamp_counter_checker #(.ONE_SECOND(ONE_SECOND)) chk (.*);

// [tb/gps_timestamp_counter_test.sv]
/* self-checking bench for gps_timestamp_counter.
   assumes a one-second count shortened to 16 */
module gps_timestamp_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] LIM = 24'h000010;
  logic clock = 0, rst = 1, ce = 1, req = 0, alarm_clear = 0, ref_clock_5mhz, second_valid_strobe, alarm_led_ff;
  logic [19:0] value = 20'h00000, bcd_time, tod_ff;
  logic [23:0] frac_ff;
  logic [15:0] lf = 16'h0053;
  int fails = 0, checks = 0;
  logic [23:0] held;
  gps_receiver_model rx (.*);
  gps_timestamp_counter #(.ONE_SECOND(LIM)) uut (.*);
  initial forever #10 clock = ~clock;
  function logic [15:0] nxt_lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task complete_run;
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task second(input logic [19:0] v);
    value <= v;
    req <= 1;
    @(posedge clock) req <= 0;
    repeat (12) @(posedge clock);
    chk(tod_ff, v);
    chk(alarm_led_ff, 0);
  endtask
  task wait_led;
    int i;
    for (i = 0; i < 500 && alarm_led_ff !== 1'b1; i++) @(posedge clock);
    if (i == 500) fails++;
    if (i == 500) complete_run;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    chk(frac_ff, 0);
    repeat (6) begin
      lf = nxt_lfsr(lf);
      second({lf[3:0], lf});
    end
    ce <= 0;
    @(posedge clock);
    held = frac_ff;
    repeat (30) @(posedge clock);
    chk(frac_ff, held);
    ce <= 1;
    wait_led;
    chk(frac_ff[23], 1);
    repeat (300) @(posedge clock);
    chk({frac_ff[23], alarm_led_ff}, 3);
    alarm_clear <= 1;
    repeat (5) @(posedge clock);
    chk(alarm_led_ff, 0);
    alarm_clear <= 0;
    second(20'h23595);
    complete_run;
  end
endmodule // gps_timestamp_counter_test
